// file: pmoc_host.sv
`include "pmoc_params.svh"

module pmoc_host (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_oe,
	output logic o_res_t,
	output logic [15:0] o_res_d
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
		o_res_t = 1'b0;
		o_res_d = 16'h0000;
	end
	task automatic w(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// start or repeated start
	task automatic start();
		o_sda_oe = 1'b0;
		w(4);
		o_scl = 1'b1;
		w(4);
		o_sda_oe = 1'b1;
		w(4);
		o_scl = 1'b0;
		w(1);
	endtask
	task automatic stop();
		o_sda_oe = 1'b1;
		w(4);
		o_scl = 1'b1;
		w(4);
		o_sda_oe = 1'b0;
		w(8);
	endtask
	// sda set in low phase, sampled at end of high phase
	task automatic bit_io(input logic b, output logic r);
		o_sda_oe = !b;
		w(3);
		o_scl = 1'b1;
		w(4);
		r = i_sda;
		o_scl = 1'b0;
		w(1);
	endtask
	task automatic tx(input logic [7:0] d, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		a = !r;
	endtask
	task automatic rx(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
	// result: read data, or all-acked flag for writes
	task automatic xfer(input logic [7:0] c, input int nw,
		input logic [15:0] d, input int nr);
		logic a, k;
		logic [7:0] lo, hi;
		lo = 8'h00;
		hi = 8'h00;
		start();
		tx({`PMOC_SLAVE_ADDR, 1'b0}, k);
		tx(c, a);
		k &= a;
		if (nw > 0) begin
			tx(d[7:0], a);
			k &= a;
		end
		if (nw > 1) begin
			tx(d[15:8], a);
			k &= a;
		end
		if (nr > 0) begin
			start();
			tx({`PMOC_SLAVE_ADDR, 1'b1}, a);
			rx(nr == 1, lo);
			if (nr > 1) rx(1'b1, hi);
		end
		stop();
		o_res_d = (nr > 0) ? {hi, lo} : {15'h0000, k};
		o_res_t = !o_res_t;
	endtask
endmodule // pmoc_host

// file: pmoc_params.svh
`ifndef PMOC_PARAMS_SVH
`define PMOC_PARAMS_SVH

`define PMOC_NCH 8
`define PMOC_NWORDS 10

`define PMOC_CMD_PAGE 8'h00
`define PMOC_CMD_OPER 8'h01
`define PMOC_CMD_ONOFF 8'h02
`define PMOC_CMD_CLRF 8'h03
`define PMOC_CMD_WP 8'h10
`define PMOC_CMD_STORE 8'h15
`define PMOC_CMD_RESTORE 8'h16
`define PMOC_CMD_CAP 8'h19
`define PMOC_CMD_VMODE 8'h20
`define PMOC_CMD_SETPT 8'h21
`define PMOC_CMD_CEIL 8'h24
`define PMOC_CMD_MHIGH 8'h25
`define PMOC_CMD_MLOW 8'h26
`define PMOC_CMD_OVF 8'h40
`define PMOC_CMD_OVW 8'h42
`define PMOC_CMD_UVW 8'h43
`define PMOC_CMD_UVF 8'h44
`define PMOC_CMD_PGON 8'h5E
`define PMOC_CMD_PGOFF 8'h5F
`define PMOC_CMD_STATV 8'h7A
`define PMOC_CMD_MASK 8'hE4

`define PMOC_PAGE_ALL 8'hFF
`define PMOC_NO_WORD 4'hF
`define PMOC_WP_L1 8'h80
`define PMOC_WP_L2 8'h40
`define PMOC_WP_NONE 8'h00
`define PMOC_CAP_VAL 8'hE0
`define PMOC_VMODE_VAL 8'h13

`define PMOC_OPER_ON 2'b10
`define PMOC_OPER_OFF_NOW 2'b00
`define PMOC_OO_CTLON 4
`define PMOC_OO_BUS 3
`define PMOC_OO_PIN 2
`define PMOC_OO_FAST 0

`define PMOC_ONOFF_RST 8'h1E
`define PMOC_OPER_RST 8'h80
`define PMOC_MASK_RST 8'hFF
`define PMOC_SLAVE_ADDR 7'h5C
`define PMOC_TON_CYC 16'h0100
`define PMOC_TOFF_CYC 16'h0100
`define PMOC_NVM_CYC 16'h0040

`endif

// file: pmoc_pkg.sv
`include "pmoc_params.svh"

package pmoc_pkg;

	typedef enum logic [1:0] {
		CH_OFF = 2'b00,
		CH_TON = 2'b01,
		CH_ON = 2'b10,
		CH_TOFF = 2'b11
	} pmoc_ch_t;

	typedef enum logic [2:0] {
		B_IDLE = 3'b000,
		B_ADDR = 3'b001,
		B_ACK = 3'b010,
		B_RX = 3'b011,
		B_TX = 3'b100,
		B_RACK = 3'b101
	} pmoc_bus_t;

	typedef logic [`PMOC_NCH-1:0][`PMOC_NWORDS-1:0][15:0] pmoc_words_t;
	typedef logic [`PMOC_NCH-1:0][7:0] pmoc_bytes_t;

	typedef struct packed {
		logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, en_m, en_s;
		pmoc_bus_t st;
		logic [3:0] bitcnt;
		logic [7:0] shreg, cmd, wlo, whi, page, wp, mask, nvm_wp, nvm_mask;
		logic rw, addr_ok, rd_hi, sda_oe, busy, restore, cml;
		logic cfg_tog, clr_tog;
		logic [1:0] nbytes;
		logic [15:0] busy_cnt;
		logic [`PMOC_NCH-1:0] stat_m, stat_s;
		pmoc_bytes_t onoff, oper, nvm_onoff;
		pmoc_words_t words, nvm_words;
	} pmoc_link_t;

	typedef struct packed {
		logic tog_m, tog_s, tog_p, clr_m, clr_s, clr_p;
		logic busy_m, busy_s, cml_m, cml_s, vin_m, vin_s, alert;
		logic [`PMOC_NCH-1:0] pin_m, pin_s, flt_m, flt_s;
		logic [`PMOC_NCH-1:0] en, latched, status;
		pmoc_bytes_t onoff, oper;
		pmoc_ch_t [`PMOC_NCH-1:0] st;
		logic [`PMOC_NCH-1:0][15:0] cnt;
	} pmoc_sys_t;

endpackage

// file: pmoc_top.sv
`include "pmoc_params.svh"

// Function
// - global page writes on/off config
// - sequencing waits for input voltage ok
// - config bits 7:5 read zero, bit1 one
// - autonomous mode powers up with sequencing
// - controlled mode needs pin and/or bus
// - bus-use bit gates operation control
// - pin-use bit gates control pin
// - pin fast-off drops enable at once
// - fault clear clears status, releases alert
// - fault clear never restarts latched channel
// - persisting fault sets status again
// - fault clear acts on current page only
// - all commands readable at any lock
// - level 1 allows lock, page, store
// - level 2 adds operation, mask, clear
// - zero lock value allows all writes
// - restore on command and after reset
// - writes refused while store/restore runs
// - store copies words, config, lock, mask; monitoring suspended
// - capability byte reads E0
// - number format byte reads 13
// - sixteen-bit unsigned output voltage words
// - value is mantissa times two^-13
// - only operation and config go global
module pmoc_top #(
	parameter logic [6:0] SLAVE_ADDR = `PMOC_SLAVE_ADDR,
	parameter logic [15:0] TON_CYC = `PMOC_TON_CYC,
	parameter logic [15:0] TOFF_CYC = `PMOC_TOFF_CYC,
	parameter logic [15:0] NVM_CYC = `PMOC_NVM_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	input wire logic i_link_clk,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic [`PMOC_NCH-1:0] i_channel_control_pin,
	input wire logic i_input_voltage_sense_ok,
	input wire logic [`PMOC_NCH-1:0] i_fault_cond,
	output logic [`PMOC_NCH-1:0] o_converter_enable_out,
	output logic o_host_alert_line_out,
	output logic o_host_alert_line_oe
);

	pmoc_pkg::pmoc_link_t l_r, l_nxt;
	pmoc_pkg::pmoc_sys_t s_r, s_nxt;
	logic l_rise, l_fall, l_start, l_stop, l_commit, pg_ok, glob;
	logic [2:0] pg;
	logic [3:0] cmd_idx;
	logic [15:0] rd_word;
	logic [7:0] rd_byte;

	function automatic logic [3:0] word_idx(input logic [7:0] c);
		case (c)
			`PMOC_CMD_SETPT: word_idx = 4'h0;
			`PMOC_CMD_CEIL: word_idx = 4'h1;
			`PMOC_CMD_MHIGH: word_idx = 4'h2;
			`PMOC_CMD_MLOW: word_idx = 4'h3;
			`PMOC_CMD_OVF: word_idx = 4'h4;
			`PMOC_CMD_OVW: word_idx = 4'h5;
			`PMOC_CMD_UVW: word_idx = 4'h6;
			`PMOC_CMD_UVF: word_idx = 4'h7;
			`PMOC_CMD_PGON: word_idx = 4'h8;
			`PMOC_CMD_PGOFF: word_idx = 4'h9;
			default: word_idx = `PMOC_NO_WORD;
		endcase
	endfunction

	function automatic logic wr_ok(input logic [7:0] wp, input logic [7:0] c);
		wr_ok = (wp == `PMOC_WP_NONE) || (c == `PMOC_CMD_WP) ||
			(c == `PMOC_CMD_PAGE) || (c == `PMOC_CMD_STORE) ||
			((wp == `PMOC_WP_L2) && ((c == `PMOC_CMD_OPER) ||
			(c == `PMOC_CMD_MASK) || (c == `PMOC_CMD_CLRF)));
	endfunction

	assign l_rise = l_r.en_s & l_r.scl_s & ~l_r.scl_p;
	assign l_fall = l_r.en_s & ~l_r.scl_s & l_r.scl_p;
	assign l_start = l_r.en_s & l_r.scl_s & l_r.scl_p & l_r.sda_p & ~l_r.sda_s;
	assign l_stop = l_r.en_s & l_r.scl_s & l_r.scl_p & ~l_r.sda_p & l_r.sda_s;
	assign l_commit = l_stop & (l_r.st != pmoc_pkg::B_IDLE) & ~l_r.rw &
		(l_r.nbytes != 2'd0) & ~l_r.busy;
	assign pg = l_r.page[2:0];
	assign pg_ok = l_r.page < 8'h08;
	assign glob = l_r.page == `PMOC_PAGE_ALL;
	assign cmd_idx = word_idx(l_r.cmd);
	assign rd_byte = l_r.rd_hi ? rd_word[15:8] : rd_word[7:0];

	// read mux, open at every lock level
	always_comb begin
		rd_word = 16'h0000;
		case (l_r.cmd)
			`PMOC_CMD_PAGE: rd_word = {8'h00, l_r.page};
			`PMOC_CMD_OPER: if (pg_ok) rd_word = {8'h00, l_r.oper[pg][7:2], 2'b00};
			`PMOC_CMD_ONOFF: if (pg_ok) rd_word = {8'h00, 3'b000,
				l_r.onoff[pg][4:2], 1'b1, l_r.onoff[pg][0]};
			`PMOC_CMD_WP: rd_word = {8'h00, l_r.wp};
			`PMOC_CMD_CAP: rd_word = {8'h00, `PMOC_CAP_VAL};
			`PMOC_CMD_VMODE: rd_word = {8'h00, `PMOC_VMODE_VAL};
			`PMOC_CMD_MASK: rd_word = {8'h00, l_r.mask};
			`PMOC_CMD_STATV: if (pg_ok) rd_word = {15'h0000, l_r.stat_s[pg]};
			default: if (cmd_idx != `PMOC_NO_WORD && pg_ok)
				rd_word = l_r.words[pg][cmd_idx];
		endcase
	end

	// link side: serial slave, command registers, nvm copy
	always_comb begin
		l_nxt = l_r;
		l_nxt.scl_m = i_scl;
		l_nxt.scl_s = l_r.scl_m;
		l_nxt.sda_m = i_sda;
		l_nxt.sda_s = l_r.sda_m;
		l_nxt.en_m = i_clk_en;
		l_nxt.en_s = l_r.en_m;
		l_nxt.stat_m = s_r.status;
		l_nxt.stat_s = l_r.stat_m;
		if (l_r.en_s) begin
			l_nxt.scl_p = l_r.scl_s;
			l_nxt.sda_p = l_r.sda_s;
			if (l_r.busy) begin
				if (l_r.busy_cnt == 16'h0000) begin
					l_nxt.busy = 1'b0;
					l_nxt.cfg_tog = ~l_r.cfg_tog;
					if (l_r.restore) begin
						l_nxt.words = l_r.nvm_words;
						l_nxt.onoff = l_r.nvm_onoff;
						l_nxt.wp = l_r.nvm_wp;
						l_nxt.mask = l_r.nvm_mask;
					end else begin
						l_nxt.nvm_words = l_r.words;
						l_nxt.nvm_onoff = l_r.onoff;
						l_nxt.nvm_wp = l_r.wp;
						l_nxt.nvm_mask = l_r.mask;
					end
				end else begin
					l_nxt.busy_cnt = l_r.busy_cnt - 16'h0001;
				end
			end
			if (l_commit) begin
				if (!wr_ok(l_r.wp, l_r.cmd)) begin
					l_nxt.cml = 1'b1;
				end else begin
					case (l_r.cmd)
						`PMOC_CMD_PAGE: begin
							if (l_r.nbytes == 2'd2 && (l_r.wlo < 8'h08 ||
								l_r.wlo == `PMOC_PAGE_ALL)) begin
								l_nxt.page = l_r.wlo;
							end else begin
								l_nxt.cml = 1'b1;
							end
						end
						`PMOC_CMD_OPER, `PMOC_CMD_ONOFF: begin
							if (l_r.nbytes == 2'd2 && (pg_ok || glob)) begin
								for (int i = 0; i < `PMOC_NCH; i++) begin
									if ((pg_ok && pg == i[2:0]) ||
										(glob && l_r.mask[i])) begin
										if (l_r.cmd == `PMOC_CMD_OPER) begin
											l_nxt.oper[i] = l_r.wlo;
										end else begin
											l_nxt.onoff[i] = l_r.wlo;
										end
									end
								end
								l_nxt.cfg_tog = ~l_r.cfg_tog;
							end else begin
								l_nxt.cml = 1'b1;
							end
						end
						`PMOC_CMD_CLRF: begin
							if (l_r.nbytes == 2'd1) begin
								l_nxt.cml = 1'b0;
								l_nxt.clr_tog = ~l_r.clr_tog;
							end else begin
								l_nxt.cml = 1'b1;
							end
						end
						`PMOC_CMD_WP: begin
							if (l_r.nbytes == 2'd2 && (l_r.wlo == `PMOC_WP_NONE ||
								l_r.wlo == `PMOC_WP_L1 ||
								l_r.wlo == `PMOC_WP_L2)) begin
								l_nxt.wp = l_r.wlo;
							end else begin
								l_nxt.cml = 1'b1;
							end
						end
						`PMOC_CMD_STORE, `PMOC_CMD_RESTORE: begin
							if (l_r.nbytes == 2'd1) begin
								l_nxt.busy = 1'b1;
								l_nxt.busy_cnt = NVM_CYC;
								l_nxt.restore = l_r.cmd == `PMOC_CMD_RESTORE;
							end else begin
								l_nxt.cml = 1'b1;
							end
						end
						`PMOC_CMD_MASK: begin
							if (l_r.nbytes == 2'd2) begin
								l_nxt.mask = l_r.wlo;
							end else begin
								l_nxt.cml = 1'b1;
							end
						end
						default: begin
							if (cmd_idx != `PMOC_NO_WORD && l_r.nbytes == 2'd3 &&
								pg_ok) begin
								l_nxt.words[pg][cmd_idx] = {l_r.whi, l_r.wlo};
							end else begin
								l_nxt.cml = 1'b1;
							end
						end
					endcase
				end
			end
			if (l_stop) begin
				l_nxt.st = pmoc_pkg::B_IDLE;
				l_nxt.sda_oe = 1'b0;
			end else if (l_start) begin
				l_nxt.st = pmoc_pkg::B_ADDR;
				l_nxt.bitcnt = 4'h0;
				l_nxt.nbytes = 2'd0;
				l_nxt.sda_oe = 1'b0;
			end else begin
				unique case (l_r.st)
					pmoc_pkg::B_IDLE: l_nxt.sda_oe = 1'b0;
					pmoc_pkg::B_ADDR, pmoc_pkg::B_RX: begin
						if (l_rise) begin
							l_nxt.shreg = {l_r.shreg[6:0], l_r.sda_s};
							l_nxt.bitcnt = l_r.bitcnt + 4'h1;
						end else if (l_fall && l_r.bitcnt == 4'h8) begin
							l_nxt.bitcnt = 4'h0;
							l_nxt.st = pmoc_pkg::B_ACK;
							if (l_r.st == pmoc_pkg::B_ADDR) begin
								l_nxt.addr_ok = l_r.shreg[7:1] == SLAVE_ADDR;
								l_nxt.rw = l_r.shreg[0];
								l_nxt.rd_hi = 1'b0;
								l_nxt.sda_oe = l_r.shreg[7:1] == SLAVE_ADDR;
							end else begin
								l_nxt.addr_ok = ~l_r.busy;
								l_nxt.sda_oe = ~l_r.busy;
								if (!l_r.busy) begin
									case (l_r.nbytes)
										2'd0: l_nxt.cmd = l_r.shreg;
										2'd1: l_nxt.wlo = l_r.shreg;
										default: l_nxt.whi = l_r.shreg;
									endcase
									if (l_r.nbytes != 2'd3) begin
										l_nxt.nbytes = l_r.nbytes + 2'd1;
									end
								end
							end
						end
					end
					pmoc_pkg::B_ACK: begin
						if (l_fall) begin
							if (!l_r.addr_ok) begin
								l_nxt.st = pmoc_pkg::B_IDLE;
								l_nxt.sda_oe = 1'b0;
							end else if (l_r.rw) begin
								l_nxt.st = pmoc_pkg::B_TX;
								l_nxt.shreg = rd_byte;
								l_nxt.sda_oe = ~rd_byte[7];
								l_nxt.rd_hi = 1'b1;
							end else begin
								l_nxt.st = pmoc_pkg::B_RX;
								l_nxt.sda_oe = 1'b0;
							end
						end
					end
					pmoc_pkg::B_TX: begin
						if (l_rise) begin
							l_nxt.shreg = {l_r.shreg[6:0], 1'b0};
							l_nxt.bitcnt = l_r.bitcnt + 4'h1;
						end else if (l_fall) begin
							if (l_r.bitcnt == 4'h8) begin
								l_nxt.bitcnt = 4'h0;
								l_nxt.sda_oe = 1'b0;
								l_nxt.st = pmoc_pkg::B_RACK;
							end else begin
								l_nxt.sda_oe = ~l_r.shreg[7];
							end
						end
					end
					pmoc_pkg::B_RACK: begin
						if (l_rise) begin
							l_nxt.addr_ok = ~l_r.sda_s;
						end else if (l_fall) begin
							l_nxt.st = l_r.addr_ok ? pmoc_pkg::B_TX : pmoc_pkg::B_IDLE;
							l_nxt.shreg = rd_byte;
							l_nxt.sda_oe = l_r.addr_ok & ~rd_byte[7];
							l_nxt.rd_hi = 1'b1;
						end
					end
					default: l_nxt.st = pmoc_pkg::B_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			l_r <= '0;
			l_r.scl_m <= 1'b1;
			l_r.scl_s <= 1'b1;
			l_r.scl_p <= 1'b1;
			l_r.sda_m <= 1'b1;
			l_r.sda_s <= 1'b1;
			l_r.sda_p <= 1'b1;
			l_r.mask <= `PMOC_MASK_RST;
			l_r.nvm_mask <= `PMOC_MASK_RST;
			l_r.onoff <= {`PMOC_NCH{`PMOC_ONOFF_RST}};
			l_r.nvm_onoff <= {`PMOC_NCH{`PMOC_ONOFF_RST}};
			l_r.oper <= {`PMOC_NCH{`PMOC_OPER_RST}};
			l_r.busy <= 1'b1;
			l_r.restore <= 1'b1;
			l_r.busy_cnt <= NVM_CYC;
		end else begin
			l_r <= l_nxt;
		end
	end

	// system side: channel on/off sequencing, fault status, alert
	always_comb begin
		logic want, fast, bus_on, pin_ok, bus_ok;
		want = 1'b0;
		fast = 1'b0;
		bus_on = 1'b0;
		pin_ok = 1'b0;
		bus_ok = 1'b0;
		s_nxt = s_r;
		s_nxt.tog_m = l_r.cfg_tog;
		s_nxt.tog_s = s_r.tog_m;
		s_nxt.clr_m = l_r.clr_tog;
		s_nxt.clr_s = s_r.clr_m;
		s_nxt.busy_m = l_r.busy;
		s_nxt.busy_s = s_r.busy_m;
		s_nxt.cml_m = l_r.cml;
		s_nxt.cml_s = s_r.cml_m;
		s_nxt.vin_m = i_input_voltage_sense_ok;
		s_nxt.vin_s = s_r.vin_m;
		s_nxt.pin_m = i_channel_control_pin;
		s_nxt.pin_s = s_r.pin_m;
		s_nxt.flt_m = i_fault_cond;
		s_nxt.flt_s = s_r.flt_m;
		if (i_clk_en) begin
			s_nxt.tog_p = s_r.tog_s;
			s_nxt.clr_p = s_r.clr_s;
			if (s_r.tog_s != s_r.tog_p) begin
				s_nxt.onoff = l_r.onoff;
				s_nxt.oper = l_r.oper;
			end
			if (s_r.clr_s != s_r.clr_p && pg_ok) begin
				s_nxt.status[pg] = 1'b0;
			end
			for (int i = 0; i < `PMOC_NCH; i++) begin
				bus_on = s_r.oper[i][7:6] == `PMOC_OPER_ON;
				pin_ok = ~s_r.onoff[i][`PMOC_OO_PIN] | s_r.pin_s[i];
				bus_ok = ~s_r.onoff[i][`PMOC_OO_BUS] | bus_on;
				want = ~s_r.onoff[i][`PMOC_OO_CTLON] |
					((s_r.onoff[i][`PMOC_OO_BUS] | s_r.onoff[i][`PMOC_OO_PIN]) &
					pin_ok & bus_ok);
				fast = (s_r.onoff[i][`PMOC_OO_PIN] & ~s_r.pin_s[i] &
					s_r.onoff[i][`PMOC_OO_FAST]) |
					(s_r.onoff[i][`PMOC_OO_BUS] &
					s_r.oper[i][7:6] == `PMOC_OPER_OFF_NOW);
				if (!want) begin
					s_nxt.latched[i] = 1'b0;
				end
				if (s_r.flt_s[i] && !s_r.busy_s) begin
					s_nxt.status[i] = 1'b1;
					if (s_r.st[i] != pmoc_pkg::CH_OFF) begin
						s_nxt.latched[i] = 1'b1;
					end
				end
				unique case (s_r.st[i])
					pmoc_pkg::CH_OFF: begin
						if (want && s_r.vin_s && !s_nxt.latched[i]) begin
							s_nxt.st[i] = (TON_CYC == 16'h0000) ?
								pmoc_pkg::CH_ON : pmoc_pkg::CH_TON;
							s_nxt.en[i] = TON_CYC == 16'h0000;
							s_nxt.cnt[i] = TON_CYC;
						end
					end
					pmoc_pkg::CH_TON: begin
						if (!want || s_nxt.latched[i]) begin
							s_nxt.st[i] = pmoc_pkg::CH_OFF;
						end else if (s_r.cnt[i] <= 16'h0001) begin
							s_nxt.st[i] = pmoc_pkg::CH_ON;
							s_nxt.en[i] = 1'b1;
						end else begin
							s_nxt.cnt[i] = s_r.cnt[i] - 16'h0001;
						end
					end
					pmoc_pkg::CH_ON: begin
						if (s_nxt.latched[i] || (!want && fast)) begin
							s_nxt.st[i] = pmoc_pkg::CH_OFF;
							s_nxt.en[i] = 1'b0;
						end else if (!want) begin
							s_nxt.st[i] = pmoc_pkg::CH_TOFF;
							s_nxt.cnt[i] = TOFF_CYC;
						end
					end
					pmoc_pkg::CH_TOFF: begin
						if (s_nxt.latched[i] || fast || s_r.cnt[i] <= 16'h0001) begin
							s_nxt.st[i] = pmoc_pkg::CH_OFF;
							s_nxt.en[i] = 1'b0;
						end else if (want) begin
							s_nxt.st[i] = pmoc_pkg::CH_ON;
						end else begin
							s_nxt.cnt[i] = s_r.cnt[i] - 16'h0001;
						end
					end
				endcase
			end
			s_nxt.alert = (|s_nxt.status) | s_r.cml_s;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s_r <= '0;
			s_r.onoff <= {`PMOC_NCH{`PMOC_ONOFF_RST}};
			s_r.oper <= {`PMOC_NCH{`PMOC_OPER_RST}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_converter_enable_out = s_r.en;
	assign o_host_alert_line_out = 1'b0;
	assign o_host_alert_line_oe = s_r.alert;
	assign o_sda_out = 1'b0;
	assign o_sda_oe = l_r.sda_oe;

	fast_off_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_clk_en && s_r.st[0] == pmoc_pkg::CH_ON && !s_r.latched[0] &&
		s_r.onoff[0][4] && s_r.onoff[0][2] && s_r.onoff[0][0] &&
		!s_r.pin_s[0]) |=> !s_r.en[0])
		else $error("fast off did not drop enable");
	vin_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(s_r.st[0] == pmoc_pkg::CH_OFF && !s_r.vin_s) |=> !s_r.en[0])
		else $error("channel started without input voltage");
	never_on_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(s_r.st[0] == pmoc_pkg::CH_OFF && s_r.onoff[0][4:2] == 3'b100)
		|=> s_r.st[0] == pmoc_pkg::CH_OFF)
		else $error("channel left off with no on source");
	auto_on_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_clk_en && s_r.st[0] == pmoc_pkg::CH_OFF && !s_r.onoff[0][4] &&
		s_r.vin_s && !s_r.latched[0] && !(s_r.flt_s[0] && !s_r.busy_s))
		|=> s_r.st[0] != pmoc_pkg::CH_OFF)
		else $error("autonomous channel did not start");
	latch_off_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_r.latched[0] |-> !s_r.en[0])
		else $error("latched channel is enabled");
	refault_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_clk_en && s_r.flt_s[0] && !s_r.busy_s) |=> s_r.status[0] ##1 s_r.alert)
		else $error("persisting fault not flagged");
	alert_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(|s_r.status) && $stable(s_r.status) |-> o_host_alert_line_oe)
		else $error("alert released with status set");
	onoff_rd_a: assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
		(l_fall && l_r.st == pmoc_pkg::B_ACK && l_r.addr_ok && l_r.rw &&
		l_r.cmd == `PMOC_CMD_ONOFF && pg_ok)
		|=> l_r.shreg[7:5] == 3'b000 && l_r.shreg[1])
		else $error("config readback bits wrong");
	cap_rd_a: assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
		(l_fall && l_r.st == pmoc_pkg::B_ACK && l_r.addr_ok && l_r.rw &&
		l_r.cmd == `PMOC_CMD_CAP) |=> l_r.shreg == `PMOC_CAP_VAL)
		else $error("capability byte wrong");
	busy_nack_a: assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
		(l_fall && l_r.busy && l_r.st == pmoc_pkg::B_RX && l_r.bitcnt == 4'h8)
		|=> !l_r.sda_oe)
		else $error("write acked while nvm busy");
	wp_lock_a: assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
		(l_commit && l_r.wp == `PMOC_WP_L1 && l_r.cmd == `PMOC_CMD_OPER)
		|=> l_r.oper == $past(l_r.oper) && l_r.cml)
		else $error("locked write was taken");

endmodule // pmoc_top

// file: tb.sv
`include "pmoc_params.svh"

module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic lclk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic vin = 1'b0;
	logic [7:0] pin = 8'h00;
	logic [7:0] flt = 8'h00;
	logic [7:0] en;
	logic al, scl, hoe, doe, ht, sdo, alo;
	logic pt = 1'b0;
	logic [15:0] hd, pd;
	wire sda;
	int n_errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [15:0] exp_q[$];
	logic [31:0] lfsr = 32'hAFC95BC5;
	logic [7:0] cf[7] = '{8'h02, 8'h12, 8'h1A, 8'h1A, 8'h16, 8'h1E, 8'h1E};
	logic [6:0] ops = 7'h26;
	logic [7:0] pc = 8'h00;
	logic po = 1'b1;
	always #10 clk = !clk;
	initial begin
		#37;
		forever #80 lclk = !lclk;
	end
	assign sda = !(hoe | doe);
	pmoc_top #(.TON_CYC(16'h0004), .TOFF_CYC(16'h0010),
		.NVM_CYC(16'h00C0)) u_dut (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(ce),
		.i_link_clk(lclk), .i_scl(scl), .i_sda(sda),
		.o_sda_out(sdo), .o_sda_oe(doe), .i_channel_control_pin(pin),
		.i_input_voltage_sense_ok(vin), .i_fault_cond(flt),
		.o_converter_enable_out(en), .o_host_alert_line_out(alo),
		.o_host_alert_line_oe(al));
	pmoc_host u_host (.i_clk(lclk), .i_sda(sda), .o_scl(scl),
		.o_sda_oe(hoe), .o_res_t(ht), .o_res_d(hd));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] want(input logic [7:0] c,
		input logic op, input logic [7:0] p);
		if (!c[4]) return 8'hFF;
		if (!(c[3] | c[2])) return 8'h00;
		return (c[3] && !op) ? 8'h00 : (c[2] ? p : 8'hFF);
	endfunction
	task automatic end_sim();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	always @(ht) begin
		#1;
		if (cyc > 0) cmp(exp_q.pop_front(), hd);
	end
	always @(pt) begin
		#1;
		if (cyc > 0) cmp(exp_q.pop_front(), pd);
	end
	task automatic wr(input logic [7:0] c, input int n,
		input logic [15:0] d, input logic ok);
		exp_q.push_back({15'h0000, ok});
		u_host.xfer(c, n, d, 0);
	endtask
	task automatic wb(input logic [7:0] c, input logic [7:0] d);
		wr(c, 1, {8'h00, d}, 1'b1);
	endtask
	task automatic clr();
		wr(`PMOC_CMD_CLRF, 0, 16'h0000, 1'b1);
	endtask
	task automatic rd(input logic [7:0] c, input int n, input logic [15:0] e);
		exp_q.push_back(e);
		u_host.xfer(c, 0, 16'h0000, n);
	endtask
	// probe open-drain levels, alert (when a is set) and enables
	task automatic pr(input logic a, input logic [8:0] e, input int n);
		repeat (n) @(negedge clk);
		exp_q.push_back({7'h00, e[8] & a, e[7:0]});
		pd = {5'h00, sdo, alo, al & a, en};
		pt = !pt;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 100000) begin
			n_errors++;
			end_sim();
		end
	end
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		wr(`PMOC_CMD_OPER, 1, 16'h0080, 1'b0);
		rd(`PMOC_CMD_CAP, 1, 16'h00E0);
		rd(`PMOC_CMD_VMODE, 1, 16'h0013);
		wb(`PMOC_CMD_ONOFF, 8'hFF);
		rd(`PMOC_CMD_ONOFF, 1, 16'h001F);
		wb(`PMOC_CMD_ONOFF, 8'h00);
		pr(1'b0, 9'h000, 60);
		vin = 1'b1;
		pr(1'b0, 9'h001, 60);
		wb(`PMOC_CMD_PAGE, `PMOC_PAGE_ALL);
		for (int k = 0; k < 7; k++) begin
			if (cf[k] != pc) wb(`PMOC_CMD_ONOFF, cf[k]);
			if (ops[k] != po) wb(`PMOC_CMD_OPER,
				{ops[k] ? `PMOC_OPER_ON : `PMOC_OPER_OFF_NOW, 6'h00});
			pc = cf[k];
			po = ops[k];
			repeat (2) begin
				@(negedge clk);
				lfsr = nxt(lfsr);
				pin = lfsr[7:0];
				pr(1'b0, {1'b0, want(cf[k], ops[k], pin)}, 60);
			end
		end
		for (int k = 0; k < 2; k++) begin
			wb(`PMOC_CMD_ONOFF, k ? 8'h16 : 8'h17);
			@(negedge clk);
			pin = 8'hFF;
			pr(1'b0, 9'h0FF, 60);
			pin = 8'h00;
			pr(1'b0, k ? 9'h0FF : 9'h000, 5);
			repeat (60) @(negedge clk);
		end
		wr(`PMOC_CMD_SETPT, 2, 16'h1234, 1'b1);
		pr(1'b1, 9'h100, 2);
		wb(`PMOC_CMD_PAGE, 8'h00);
		clr();
		wr(`PMOC_CMD_SETPT, 2, 16'h9800, 1'b1);
		wb(`PMOC_CMD_WP, `PMOC_WP_L1);
		wr(`PMOC_CMD_SETPT, 2, 16'h1234, 1'b1);
		wb(`PMOC_CMD_OPER, 8'h80);
		clr();
		pr(1'b1, 9'h100, 2);
		rd(`PMOC_CMD_WP, 1, 16'h0080);
		wb(`PMOC_CMD_WP, `PMOC_WP_L2);
		clr();
		pr(1'b1, 9'h000, 2);
		wb(`PMOC_CMD_WP, 8'h20);
		pr(1'b1, 9'h100, 2);
		wb(`PMOC_CMD_WP, `PMOC_WP_NONE);
		clr();
		rd(`PMOC_CMD_SETPT, 2, 16'h9800);
		@(negedge clk);
		ce = 1'b0;
		pin = 8'hFF;
		pr(1'b0, 9'h000, 20);
		ce = 1'b1;
		pr(1'b1, 9'h0FF, 60);
		flt = 8'h01;
		pr(1'b1, 9'h1FE, 20);
		clr();
		pr(1'b1, 9'h1FE, 2);
		flt = 8'h00;
		clr();
		pr(1'b1, 9'h0FE, 2);
		flt = 8'h02;
		pr(1'b1, 9'h1FC, 20);
		flt = 8'h00;
		clr();
		pr(1'b1, 9'h1FC, 2);
		pin = 8'h00;
		pr(1'b0, 9'h000, 60);
		wr(`PMOC_CMD_STORE, 0, 16'h0000, 1'b1);
		wr(`PMOC_CMD_ONOFF, 1, 16'h0012, 1'b0);
		wb(`PMOC_CMD_ONOFF, 8'h12);
		wr(`PMOC_CMD_RESTORE, 0, 16'h0000, 1'b1);
		u_host.w(250);
		rd(`PMOC_CMD_ONOFF, 1, 16'h0016);
		wb(`PMOC_CMD_PAGE, `PMOC_PAGE_ALL);
		wb(`PMOC_CMD_MASK, 8'h0F);
		wb(`PMOC_CMD_ONOFF, 8'h00);
		pr(1'b0, 9'h00F, 60);
		repeat (4) @(negedge clk);
		end_sim();
	end
endmodule // tb
